/* dv/ddr_byte_lane_placement_tb.sv */
// Self-checking bench: host model on the pins, bench as sequencer.
// Assumes the package and header of the lane block are compiled first.
`timescale 1ns/1ps
module ddr_byte_lane_placement_tb
    import ddrbl_pkg::*;
();
    logic mclk = 0, sys_rst = 1, flip = 0, cmd_valid = 0, data_phase = 0;
    logic xfer_is_read = 0, xfer_zero_latency = 0, rd_next, wr_valid, reg_space;
    logic cs_n, bus_clock, strobe_h, strobe_h_oe, dq_h_oe, strobe_out, strobe_oe, dq_oe;
    logic [7:0] dq_h, dq_out;
    logic [47:0] command_address_word = 48'h0;
    logic [15:0] rd_word = 16'h0000;
    logic [31:0] seed = 32'h72C9B5D4;
    ddrbl_wr_type wr_word;
    ddrbl_wr_type exp_q[$];
    int fail_count = 0, checked = 0, rd_cnt = 0;
    // Released lines float: a changing pattern, not the last value
    wire logic strobe_w = strobe_oe ? strobe_out : (strobe_h_oe ? strobe_h : flip);
    wire logic [7:0] dq_w = dq_oe ? dq_out : (dq_h_oe ? dq_h : {8{flip}});
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) flip <= ~flip;
    ddrbl_lane u_ddrbl_lane (.mclk(mclk), .sys_rst(sys_rst), .pin_cs_n(cs_n),
        .pin_bus_clock(bus_clock), .pin_strobe_in(strobe_w), .pin_dq_in(dq_w),
        .pin_strobe_out(strobe_out), .pin_strobe_oe(strobe_oe), .pin_dq_out(dq_out),
        .pin_dq_oe(dq_oe), .cmd_valid(cmd_valid), .command_address_word(command_address_word),
        .data_phase(data_phase), .xfer_is_read(xfer_is_read),
        .xfer_zero_latency(xfer_zero_latency), .rd_word(rd_word), .rd_next(rd_next),
        .wr_valid(wr_valid), .wr_word(wr_word), .reg_space(reg_space));
    ddrbl_host u_ddrbl_host (.mclk(mclk), .strobe_dev(strobe_w), .dq_dev(dq_w), .cs_n(cs_n),
        .bus_clock(bus_clock), .strobe_h(strobe_h), .strobe_h_oe(strobe_h_oe), .dq_h(dq_h),
        .dq_h_oe(dq_h_oe));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    always @(posedge mclk) begin
        #1;
        if (rd_next === 1'h1) rd_cnt++;
        if (wr_valid === 1'h1) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk(32'(wr_word), 32'(exp_q.pop_front()));
        end
    end
    task automatic txn(input logic rs, input logic rd, input logic zl, input logic ph);
        logic [15:0] w;
        logic [1:0] m;
        logic [7:0] g1, g2;
        logic l1, l2;
        int i;
        seed = nxt(seed);
        command_address_word = {rd, rs, seed, seed[13:0]};
        cmd_valid = 1'h1;
        @(posedge mclk);
        #1;
        cmd_valid = 1'h0;
        @(posedge mclk);
        #1;
        chk(32'(reg_space), 32'(rs));
        xfer_is_read = rd;
        xfer_zero_latency = zl;
        data_phase = ph;
        u_ddrbl_host.sel(1'h1);
        repeat (4) @(posedge mclk);
        #1;
        chk(32'({dq_oe, strobe_oe}), 32'({ph & rd, ph & (rd | zl)}));
        if (zl && !rd) chk(32'(strobe_out), 32'h0);
        for (i = 0; i < 4; i++) begin
            seed = nxt(seed);
            w = seed[15:0];
            m = (zl || rd) ? 2'h0 : i[1:0];
            rd_word = w;
            if (ph && !rd) exp_q.push_back({w, zl ? 2'h3 : ~m, rs});
            u_ddrbl_host.half(1'h1, w[15:8], m[1], !rd, !rd && !zl, g1, l1);
            u_ddrbl_host.half(1'h0, w[7:0], m[0], !rd, !rd && !zl, g2, l2);
            if (l1 || l2) begin
                fail_count++;
                test_done();
            end
            if (rd) chk(32'({g1, g2}), 32'(w));
        end
        data_phase = 1'h0;
        u_ddrbl_host.sel(1'h0);
        repeat (8) @(posedge mclk);
        #1;
        chk(32'({dq_oe, strobe_oe}), 32'h0);
        $display("test rs=%0d rd=%0d zl=%0d ph=%0d done", rs, rd, zl, ph);
    endtask : txn
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        sys_rst = 1'h0;
        repeat (3) @(posedge mclk);
        #1;
        txn(1'h1, 1'h0, 1'h0, 1'h1);
        txn(1'h0, 1'h0, 1'h1, 1'h1);
        txn(1'h1, 1'h1, 1'h0, 1'h1);
        txn(1'h0, 1'h1, 1'h0, 1'h1);
        txn(1'h0, 1'h0, 1'h0, 1'h1);
        txn(1'h1, 1'h0, 1'h0, 1'h0);
        chk(32'(rd_cnt), 32'h8);
        chk(32'(exp_q.size()), 32'h0);
        test_done();
    end
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule : ddr_byte_lane_placement_tb

/* dv/ddrbl_host.sv */
// Host controller model: bus clock, select, write bytes and mask.
// Assumes the bench resolves the shared lines and calls its tasks.
`timescale 1ns/1ps
module ddrbl_host (
    input wire logic mclk,
    input wire logic strobe_dev,
    input wire logic [7:0] dq_dev,
    output logic cs_n,
    output logic bus_clock,
    output logic strobe_h,
    output logic strobe_h_oe,
    output logic [7:0] dq_h,
    output logic dq_h_oe
);
    initial begin
        {cs_n, bus_clock, strobe_h, strobe_h_oe, dq_h, dq_h_oe} = 13'h1000;
    end
    // Clock stays low between frames
    task automatic sel(input logic on);
        @(posedge mclk);
        #1;
        cs_n = ~on;
        if (!on) {dq_h_oe, strobe_h_oe} = 2'h0;
    endtask : sel
    // Byte set mid-eye, edge 4 mclk later; a read waits for the strobe
    task automatic half(input logic lvl, input logic [7:0] b, input logic m, input logic wr,
            input logic mk, output logic [7:0] got, output logic late);
        int n;
        dq_h = b;
        dq_h_oe = wr;
        strobe_h = m;
        strobe_h_oe = mk;
        repeat (4) @(posedge mclk);
        #1;
        bus_clock = lvl;
        late = ~wr;
        got = 8'h00;
        for (n = 0; n < 4; n++) begin
            @(posedge mclk);
            #1;
            if (late && strobe_dev === lvl) begin
                got = dq_dev;
                late = 1'h0;
            end
        end
    endtask : half
endmodule : ddrbl_host

/* rtl/ddrbl_lane.sv */
// Byte-lane placement and write-mask handling for the 8-bit DDR memory port.
// Assumes a same-clock sequencer that decodes commands, counts latency and
// raises data_phase only during the data part of a transaction; the bus
// clock is far slower than mclk so its edges can be found by sampling.
`timescale 1ns/1ps
`include "ddrbl_params.svh"

module ddrbl_lane
    import ddrbl_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pin_cs_n,
    input wire logic pin_bus_clock,
    input wire logic pin_strobe_in,
    input wire logic [`DDRBL_BYTE_W-1:0] pin_dq_in,
    output logic pin_strobe_out,
    output logic pin_strobe_oe,
    output logic [`DDRBL_BYTE_W-1:0] pin_dq_out,
    output logic pin_dq_oe,
    input wire logic cmd_valid,
    input wire logic [`DDRBL_CMD_ADDR_W-1:0] command_address_word,
    input wire logic data_phase,
    input wire logic xfer_is_read,
    input wire logic xfer_zero_latency,
    input wire logic [`DDRBL_WORD_W-1:0] rd_word,
    output logic rd_next,
    output logic wr_valid,
    output ddrbl_wr_type wr_word,
    output logic reg_space
);

    ddrbl_pin_type pin_raw;
    ddrbl_pin_type pin_s;
    logic [$bits(ddrbl_pin_type)-1:0] pin_sync;

    assign pin_raw.cs_n = pin_cs_n;
    assign pin_raw.bus_clock = pin_bus_clock;
    assign pin_raw.read_write_strobe_mask = pin_strobe_in;
    assign pin_raw.dq = pin_dq_in;

    ddrbl_sync #(
        .WIDTH($bits(ddrbl_pin_type))
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    assign pin_s = ddrbl_pin_type'(pin_sync);

    ddrbl_phase_type phase_reg, phase_next;
    logic clk_prev_reg, clk_prev_next;
    logic space_reg, space_next;
    logic [`DDRBL_BYTE_W-1:0] hold_reg, hold_next;
    logic mask_hi_reg, mask_hi_next;
    logic [`DDRBL_BYTE_W-1:0] dq_out_reg, dq_out_next;
    logic dq_oe_reg, dq_oe_next;
    logic strobe_out_reg, strobe_out_next;
    logic strobe_oe_reg, strobe_oe_next;
    logic rd_next_reg, rd_next_next;
    logic wr_valid_reg, wr_valid_next;
    ddrbl_wr_type wr_word_reg, wr_word_next;

    logic rise_s;
    logic fall_s;
    logic act;

    // Edges are found on the synchronised copy, so dq and strobe samples are
    // taken in the same mclk cycle as the edge, well inside the centred eye
    assign rise_s = pin_s.bus_clock & ~clk_prev_reg;
    assign fall_s = ~pin_s.bus_clock & clk_prev_reg;
    assign act = data_phase & ~pin_s.cs_n;

    always_comb begin
        space_next = space_reg;
        if (cmd_valid) begin
            space_next = (command_address_word[`DDRBL_CMD_SPACE_BIT]
                == `DDRBL_CMD_SPACE_REG);
        end
    end

    always_comb begin
        clk_prev_next = pin_s.bus_clock;
        phase_next = phase_reg;
        hold_next = hold_reg;
        mask_hi_next = mask_hi_reg;
        dq_out_next = dq_out_reg;
        strobe_out_next = strobe_out_reg;
        rd_next_next = 1'b0;
        wr_valid_next = 1'b0;
        wr_word_next = wr_word_reg;
        // Lanes are owned only while the data phase is live and select is low
        dq_oe_next = act & xfer_is_read;
        strobe_oe_next = act & (xfer_is_read | xfer_zero_latency);
        if (!act) begin
            phase_next = DDRBL_PH_IDLE;
            strobe_out_next = 1'b0;
        end else if (xfer_is_read) begin
            if (rise_s) begin
                dq_out_next = rd_word[`DDRBL_UPPER_MSB:`DDRBL_UPPER_LSB];
                hold_next = rd_word[`DDRBL_LOWER_MSB:`DDRBL_LOWER_LSB];
                strobe_out_next = 1'b1;
                phase_next = DDRBL_PH_UPPER;
            end else if (fall_s && phase_reg == DDRBL_PH_UPPER) begin
                dq_out_next = hold_reg;
                strobe_out_next = 1'b0;
                rd_next_next = 1'b1;
                phase_next = DDRBL_PH_LOWER;
            end
        end else begin
            if (xfer_zero_latency) begin
                strobe_out_next = 1'b0;
            end
            if (rise_s) begin
                hold_next = pin_s.dq;
                // In a zero latency write the host does not drive the strobe, so ignore it there
                mask_hi_next = ~xfer_zero_latency & pin_s.read_write_strobe_mask;
                phase_next = DDRBL_PH_UPPER;
            end else if (fall_s && phase_reg == DDRBL_PH_UPPER) begin
                wr_word_next.data = {hold_reg, pin_s.dq};
                wr_word_next.keep[1] = ~mask_hi_reg;
                wr_word_next.keep[0] = xfer_zero_latency
                    | ~pin_s.read_write_strobe_mask;
                wr_word_next.reg_space = space_reg;
                wr_valid_next = 1'b1;
                phase_next = DDRBL_PH_LOWER;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg <= DDRBL_PH_IDLE;
            clk_prev_reg <= 1'b0;
            space_reg <= 1'b0;
            hold_reg <= `DDRBL_RST_BYTE;
            mask_hi_reg <= 1'b0;
            dq_out_reg <= `DDRBL_RST_BYTE;
            dq_oe_reg <= 1'b0;
            strobe_out_reg <= 1'b0;
            strobe_oe_reg <= 1'b0;
            rd_next_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_word_reg <= '{data: `DDRBL_RST_WORD, keep: `DDRBL_KEEP_NONE, reg_space: 1'b0};
        end else begin
            phase_reg <= phase_next;
            clk_prev_reg <= clk_prev_next;
            space_reg <= space_next;
            hold_reg <= hold_next;
            mask_hi_reg <= mask_hi_next;
            dq_out_reg <= dq_out_next;
            dq_oe_reg <= dq_oe_next;
            strobe_out_reg <= strobe_out_next;
            strobe_oe_reg <= strobe_oe_next;
            rd_next_reg <= rd_next_next;
            wr_valid_reg <= wr_valid_next;
            wr_word_reg <= wr_word_next;
        end
    end

    assign pin_strobe_out = strobe_out_reg;
    assign pin_strobe_oe = strobe_oe_reg;
    assign pin_dq_out = dq_out_reg;
    assign pin_dq_oe = dq_oe_reg;
    assign rd_next = rd_next_reg;
    assign wr_valid = wr_valid_reg;
    assign wr_word = wr_word_reg;
    assign reg_space = space_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_rd_upper;
        act && xfer_is_read && rise_s;
    endsequence

    sequence s_rd_lower;
        act && xfer_is_read && fall_s && phase_reg == DDRBL_PH_UPPER;
    endsequence

    sequence s_wr_lower;
        act && !xfer_is_read && fall_s && phase_reg == DDRBL_PH_UPPER;
    endsequence

    read_upper_a: assert property (s_rd_upper |=>
        pin_dq_out == $past(rd_word[`DDRBL_UPPER_MSB:`DDRBL_UPPER_LSB])
        && pin_strobe_out && pin_dq_oe)
        else $error("read upper byte not placed with strobe high");

    read_lower_a: assert property (s_rd_lower |=>
        pin_dq_out == $past(hold_reg) && !pin_strobe_out && pin_dq_oe && rd_next)
        else $error("read lower byte not placed with strobe low");

    read_two_bytes_a: assert property (s_rd_lower |=> rd_next ##1 !rd_next)
        else $error("read word not released once per strobe fall");

    write_upper_a: assert property ((act && !xfer_is_read && rise_s) |=>
        hold_reg == $past(pin_s.dq) && phase_reg == DDRBL_PH_UPPER)
        else $error("write upper byte not captured at rising edge");

    write_word_a: assert property (s_wr_lower |=> wr_valid &&
        wr_word.data == {$past(hold_reg), $past(pin_s.dq)})
        else $error("write word not assembled upper then lower");

    mask_lower_a: assert property (s_wr_lower ##0 !xfer_zero_latency |=>
        wr_word.keep[0] == !$past(pin_s.read_write_strobe_mask))
        else $error("lower byte keep does not follow strobe mask");

    zero_lat_full_a: assert property (s_wr_lower ##0 xfer_zero_latency |=>
        wr_word.keep == `DDRBL_KEEP_ALL)
        else $error("zero latency write was masked");

    strobe_low_a: assert property ((act && !xfer_is_read && xfer_zero_latency) [*2] |->
        pin_strobe_oe && !pin_strobe_out)
        else $error("strobe not driven low in zero latency write");

    space_sel_a: assert property (cmd_valid |=>
        reg_space == $past(command_address_word[`DDRBL_CMD_SPACE_BIT]))
        else $error("address space not taken from command bit");

endmodule : ddrbl_lane

/* rtl/ddrbl_params.svh */
// Constants of the DDR byte-lane placement block.
// Assumes inclusion by bare name from the package and the lane module.
`ifndef DDRBL_PARAMS_SVH
`define DDRBL_PARAMS_SVH

`define DDRBL_BYTE_W 8
`define DDRBL_WORD_W 16
`define DDRBL_CMD_ADDR_W 48
`define DDRBL_CMD_SPACE_BIT 46
`define DDRBL_CMD_SPACE_REG 1'b1
`define DDRBL_SYNC_STAGES 2
`define DDRBL_UPPER_MSB 15
`define DDRBL_UPPER_LSB 8
`define DDRBL_LOWER_MSB 7
`define DDRBL_LOWER_LSB 0
`define DDRBL_RST_BYTE 8'h00
`define DDRBL_RST_WORD 16'h0000
`define DDRBL_KEEP_ALL 2'h3
`define DDRBL_KEEP_NONE 2'h0

`endif

/* rtl/ddrbl_pkg.sv */
// Types of the DDR byte-lane placement block.
// Assumes ddrbl_params.svh is on the include path.
`include "ddrbl_params.svh"

package ddrbl_pkg;

    // Link pins as seen from the device, all from outside the mclk domain
    typedef struct packed {
        logic cs_n;
        logic bus_clock;
        logic read_write_strobe_mask;
        logic [`DDRBL_BYTE_W-1:0] dq;
    } ddrbl_pin_type;

    // One assembled write word with per-byte keep bits (1 = store the byte)
    typedef struct packed {
        logic [`DDRBL_WORD_W-1:0] data;
        logic [1:0] keep;
        logic reg_space;
    } ddrbl_wr_type;

    typedef enum logic [1:0] {
        DDRBL_PH_IDLE,
        DDRBL_PH_UPPER,
        DDRBL_PH_LOWER
    } ddrbl_phase_type;

endpackage : ddrbl_pkg

/* rtl/ddrbl_sync.sv */
// Two-stage synchroniser for a bundle of independent level signals.
// Assumes each bit is a level; the first stage is read only by the second.
`timescale 1ns/1ps

module ddrbl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : ddrbl_sync
